//--- rtl/dsr_pkg.sv
// Shared types and constants for the dual-clock bidirectional shift register.
// Also holds the small two-entry word buffer that the top level instantiates.
// Assumes one 40 MHz system clock; all pins arrive asynchronously.
//
// Functional notes
// - Mode high: parallel inputs load matching stages
// - Load happens only on clock-2 falling edge
// - Serial input ignored during parallel load
// - Mode low, clock-1 fall: shift right
// - Mode high, clock-2 fall: left shift via load
// - Mode change alone never alters contents
`timescale 1ns/100ps
package dsr_pkg;
	localparam int STAGES = 4;                   // Register length
	localparam int SYNC_DEPTH = 3;               // Pin synchroniser stages
	localparam logic [3:0] STAGE_RESET = 4'h0;   // Contents after reset
	localparam int BUF_DEPTH = 2;                // Output word buffer entries
	// Pin group sampled from the outside world
	typedef struct packed {
		logic mode;          // High: load/left via clock-2; low: right
		logic clk1;          // Right-shift clock
		logic clk2;          // Load / left-shift clock
		logic ser;           // Serial data for right shift
		logic [3:0] par;     // Parallel data, bit 0 feeds the first stage
	} dsr_pins_t;
	localparam dsr_pins_t PINS_RESET = '{default: 1'b0};
endpackage

// Two-entry valid/ready buffer; a stalled reader fills it, then in_ready drops
module dsr_buf #(
	parameter int W = 4,
	parameter int DEPTH = dsr_pkg::BUF_DEPTH
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Filling side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// Draining side
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	import dsr_pkg::*;
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [W-1:0] mem_q [DEPTH]; // Entry storage
	logic [W-1:0] mem_d [DEPTH];
	logic [AW-1:0] rd_q, rd_d, wr_q, wr_d; // Read and write indices
	logic [AW:0] cnt_q, cnt_d; // Occupancy
	logic push, pop;

	// Handshakes are combinational from honest occupancy
	// Compare at the counter's own width so DEPTH is not cut to zero
	assign in_ready = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data = mem_q[rd_q];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	// Next index, occupancy and storage
	always_comb begin
		mem_d = mem_q;
		wr_d = wr_q;
		rd_d = rd_q;
		if (push) begin
			mem_d[wr_q] = in_data;
			wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
		end
		if (pop) begin
			rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
		end
		cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
	end

	// Register the buffer state
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mem_q <= '{default: '0};
			rd_q <= '0;
			wr_q <= '0;
			cnt_q <= '0;
		end else begin
			mem_q <= mem_d;
			rd_q <= rd_d;
			wr_q <= wr_d;
			cnt_q <= cnt_d;
		end
	end
endmodule // dsr_buf

//--- rtl/dsr_top.sv
// Four-stage shift register with parallel load, right and left shift.
// Pins are asynchronous to clk and pass a three-flop filter; the two
// register clocks are sampled as levels and their falling edges detected.
// Each new content is also offered as a word on a buffered stream.
`timescale 1ns/100ps
module dsr_top (
	// System clock and reset
	input wire logic clk,
	input wire logic rst,
	// Pin inputs from the surrounding logic
	input wire logic mode_sel,
	input wire logic clk1_in,
	input wire logic clk2_in,
	input wire logic serial_in,
	input wire logic [dsr_pkg::STAGES-1:0] par_in,
	// Stage outputs
	output logic stage_out_first,
	output logic stage_out_second,
	output logic stage_out_third,
	output logic stage_out_fourth,
	// Stream of every new content
	output logic word_valid,
	input wire logic word_ready,
	output logic [dsr_pkg::STAGES-1:0] word_data
);
	import dsr_pkg::*;

	dsr_pins_t pins_raw; // Pins gathered into one group
	dsr_pins_t sync_q [SYNC_DEPTH]; // Synchroniser chain
	dsr_pins_t sync_d [SYNC_DEPTH];
	dsr_pins_t filt_q, filt_d; // Accepted pin levels
	logic [STAGES-1:0] stage_q, stage_d; // Register contents
	logic [STAGES-1:0] pend_word_q, pend_word_d; // Update waiting on buffer
	logic pend_q, pend_d;
	logic fall1, fall2; // Falling edges of accepted clock levels
	logic ev_load, ev_right; // Qualified operations
	logic [STAGES-1:0] base; // Contents a new operation starts from
	logic [STAGES-1:0] new_word; // Result of this cycle's operation
	logic buf_ready; // Buffer can take a word
	logic apply; // Contents change this cycle

	assign pins_raw = '{mode: mode_sel, clk1: clk1_in, clk2: clk2_in,
		ser: serial_in, par: par_in};

	// Three-flop chain; only the second and third stages are compared
	always_comb begin
		sync_d[0] = pins_raw;
		for (int i = 1; i < SYNC_DEPTH; i++) begin
			sync_d[i] = sync_q[i-1];
		end
		// A bit changes only once stages two and three agree
		filt_d = filt_q;
		for (int b = 0; b < $bits(dsr_pins_t); b++) begin
			if (sync_q[1][b] == sync_q[2][b]) begin
				filt_d[b] = sync_q[2][b];
			end
		end
	end

	// Register synchroniser and filter
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sync_q <= '{default: PINS_RESET};
			filt_q <= PINS_RESET;
		end else begin
			sync_q <= sync_d;
			filt_q <= filt_d;
		end
	end

	// Edges come from the filtered clock levels only, never from mode
	assign fall1 = filt_q.clk1 & ~filt_d.clk1;
	assign fall2 = filt_q.clk2 & ~filt_d.clk2;
	// Each mode listens to one clock; the other one is ignored
	assign ev_load = fall2 & filt_d.mode;
	assign ev_right = fall1 & ~filt_d.mode;

	// An update stalled by the buffer is still the base for the next one
	assign base = pend_q ? pend_word_q : stage_q;

	// Compute the operation result
	always_comb begin
		new_word = base;
		if (ev_load) begin
			// Left shift is this same load with outside feedback wiring
			new_word = filt_d.par;
		end else if (ev_right) begin
			new_word = {base[STAGES-2:0], filt_d.ser};
		end
	end

	// Apply when the buffer can record the word, else hold it pending
	always_comb begin
		pend_d = pend_q;
		pend_word_d = pend_word_q;
		stage_d = stage_q;
		apply = 1'b0;
		if (ev_load | ev_right | pend_q) begin
			if (buf_ready) begin
				stage_d = new_word;
				apply = 1'b1;
				pend_d = 1'b0;
			end else begin
				pend_d = 1'b1;
				pend_word_d = new_word;
			end
		end
		// No selected edge and nothing pending: contents hold
	end

	// Register stage contents and pending update
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stage_q <= STAGE_RESET;
			pend_q <= 1'b0;
			pend_word_q <= STAGE_RESET;
		end else begin
			stage_q <= stage_d;
			pend_q <= pend_d;
			pend_word_q <= pend_word_d;
		end
	end

	// Stage bit 0 is the first stage, toward which left shifts move
	assign stage_out_first = stage_q[0];
	assign stage_out_second = stage_q[1];
	assign stage_out_third = stage_q[2];
	assign stage_out_fourth = stage_q[3];

	// Word buffer; a stalled reader holds updates back rather than drop
	dsr_buf #(
		.W(STAGES),
		.DEPTH(BUF_DEPTH)
	) u_buf (
		.clk(clk),
		.rst(rst),
		.in_valid(apply),
		.in_ready(buf_ready),
		.in_data(stage_d),
		.out_valid(word_valid),
		.out_ready(word_ready),
		.out_data(word_data)
	);

	// Checks on the register behaviour
	sequence s_load_now;
		ev_load && buf_ready;
	endsequence

	sequence s_right_now;
		ev_right && buf_ready && !pend_q;
	endsequence

	sequence s_quiet;
		!fall1 && !fall2 && !pend_q;
	endsequence

	a_load_par_data: assert property (@(posedge clk) disable iff (rst)
		s_load_now |=> stage_q == $past(filt_d.par))
		else $error("parallel load did not take parallel inputs");

	a_load_needs_fall2: assert property (@(posedge clk) disable iff (rst)
		(stage_q != $past(stage_q)) && $past(filt_d.mode) && !$past(pend_q)
		|-> $past(fall2))
		else $error("load happened without clock-2 falling edge");

	a_load_no_serial: assert property (@(posedge clk) disable iff (rst)
		s_load_now ##1 1'b1 |-> stage_q[0] == $past(filt_d.par[0]))
		else $error("serial input leaked into parallel load");

	a_right_shift_step: assert property (@(posedge clk) disable iff (rst)
		s_right_now |=> stage_q == {$past(stage_q[STAGES-2:0]),
			$past(filt_d.ser)})
		else $error("right shift result wrong");

	a_left_entry_last: assert property (@(posedge clk) disable iff (rst)
		s_load_now |=> stage_out_fourth == $past(filt_d.par[3])
			&& word_valid)
		else $error("left shift serial entry missing");

	a_mode_change_hold: assert property (@(posedge clk) disable iff (rst)
		($past(filt_q.mode) != filt_q.mode) ##0 s_quiet |=> $stable(stage_q))
		else $error("mode change altered contents");

	a_unsel_clk_hold: assert property (@(posedge clk) disable iff (rst)
		fall1 && filt_d.mode && !fall2 && !pend_q
		|=> $stable(stage_q) ##1 ($stable(stage_q) || $past(fall2)))
		else $error("unselected clock changed contents");
endmodule // dsr_top

//--- sim/dsr_drv.sv
// Surrounding logic model: drives mode, clocks and data pins.
// Assumes the bench clock and the stage outputs are wired in.
`timescale 1ns/100ps
module dsr_drv (
	// Bench clock
	input wire logic clk,
	// Stage contents, bit0 first stage
	input wire logic [3:0] stage_v,
	// Pins to the register
	output logic mode_sel,
	output logic clk1_in,
	output logic clk2_in,
	output logic serial_in,
	output logic [3:0] par_in
);
	logic left_on; // Feedback wiring switched in
	logic [3:0] data_v; // Plain parallel data
	// Left shift feeds each next stage back, new bit on the last pin
	assign par_in = left_on ? {data_v[3], stage_v[3:1]} : data_v;
	initial begin
		{mode_sel, clk1_in, clk2_in, serial_in, left_on, data_v} = '0;
	end
	// Wait n edges, then act a little after the edge
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask
	// Set levels, then let the pin filter settle for 8 cycles
	task automatic hold(input logic m, input logic [1:0] ck,
		input logic [3:0] d);
		step(1);
		mode_sel = m;
		left_on = 1'h0;
		data_v = d;
		clk1_in = ck[0];
		clk2_in = ck[1];
		step(8);
	endtask
	// One operation; 8 cycles per phase beats the pin filter
	task automatic op(input logic m, input logic [1:0] ck,
		input logic lft, input logic [3:0] d, input logic s);
		step(1);
		mode_sel = m;
		left_on = lft;
		data_v = d;
		serial_in = s;
		step(8);
		clk1_in = ck[0];
		clk2_in = ck[1];
		step(8);
		clk1_in = 1'h0;
		clk2_in = 1'h0;
		step(8);
	endtask
endmodule // dsr_drv

//--- sim/test_dsr_top.sv
// Bench for the shift register: table of pin operations, then
// a reader stall and a reset in mid-run. Assumes dsr_top, dsr_drv.
`timescale 1ns/100ps
module test_dsr_top;
	// One operation and the contents it should leave
	typedef struct packed {
		logic m;
		logic [1:0] ck; // Bit0 first clock, bit1 second
		logic lft;
		logic [3:0] d;
		logic s;
		logic [3:0] q;
	} dsr_row_t;
	logic clk = 1'h0; // System clock
	logic rst = 1'h1; // Held at start
	logic word_ready = 1'h1; // Reader accepts
	wire logic mode_sel, clk1_in, clk2_in, serial_in;
	wire logic [3:0] par_in, stage_v, word_data;
	wire logic word_valid;
	int err_total = 0;
	int n_compared = 0;
	// Serial bit set in loads to prove it is ignored
	dsr_row_t rows[9] = '{
		'{1'h1, 2'h2, 1'h0, 4'ha, 1'h1, 4'ha},
		'{1'h0, 2'h1, 1'h0, 4'h0, 1'h1, 4'h5},
		'{1'h0, 2'h1, 1'h0, 4'h0, 1'h0, 4'ha},
		'{1'h1, 2'h2, 1'h1, 4'h8, 1'h0, 4'hd},
		'{1'h1, 2'h1, 1'h0, 4'h0, 1'h0, 4'hd},
		'{1'h0, 2'h2, 1'h0, 4'hf, 1'h0, 4'hd},
		'{1'h1, 2'h0, 1'h0, 4'h0, 1'h0, 4'hd},
		'{1'h0, 2'h3, 1'h0, 4'h0, 1'h0, 4'ha},
		'{1'h1, 2'h3, 1'h0, 4'h3, 1'h1, 4'h3}};
	dsr_drv drv (.clk(clk), .stage_v(stage_v), .mode_sel(mode_sel),
		.clk1_in(clk1_in), .clk2_in(clk2_in), .serial_in(serial_in),
		.par_in(par_in));
	dsr_top DUT (.clk(clk), .rst(rst), .mode_sel(mode_sel),
		.clk1_in(clk1_in), .clk2_in(clk2_in), .serial_in(serial_in),
		.par_in(par_in), .stage_out_first(stage_v[0]),
		.stage_out_second(stage_v[1]), .stage_out_third(stage_v[2]),
		.stage_out_fourth(stage_v[3]), .word_valid(word_valid),
		.word_ready(word_ready), .word_data(word_data));
	initial begin
		forever #12.5 clk = ~clk;
	end
	// Compare one value, count it, report a mismatch
	task automatic chk(input string what, input logic [3:0] exp,
		input logic [3:0] got);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Counts, then verdict
	task automatic test_done;
		$display("compared %0d mismatched %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// Whole run is about 375 cycles; over ten times that is a hang
	initial begin
		#100000;
		err_total++;
		test_done;
	end
	initial begin
		drv.step(2);
		rst = 1'h0;
		drv.step(2);
		chk("reset stages", 4'h0, stage_v);
		for (int i = 0; i < 9; i++) begin
			drv.op(rows[i].m, rows[i].ck, rows[i].lft, rows[i].d, rows[i].s);
			chk("stages", rows[i].q, stage_v);
		end
		chk("drained", 4'h0, {3'h0, word_valid});
		$display("[test] operation table done");
		// Stall the reader over three loads; the third waits pending
		word_ready = 1'h0;
		for (int i = 1; i < 4; i++) begin
			drv.op(1'h1, 2'h2, 1'h0, 4'(i), 1'h0);
		end
		for (int i = 1; i < 4; i++) begin
			chk("valid", 4'h1, {3'h0, word_valid});
			chk("word", 4'(i), word_data);
			word_ready = 1'h1;
			drv.step(1);
			word_ready = 1'h0;
			drv.step(4);
		end
		chk("empty", 4'h0, {3'h0, word_valid});
		chk("stages", 4'h3, stage_v);
		$display("[test] stall done");
		// Reset with a word waiting clears contents and buffer
		drv.op(1'h1, 2'h2, 1'h0, 4'h5, 1'h0);
		rst = 1'h1;
		drv.step(2);
		chk("valid", 4'h0, {3'h0, word_valid});
		chk("stages", 4'h0, stage_v);
		rst = 1'h0;
		word_ready = 1'h1;
		drv.step(2);
		chk("after release", 4'h0, stage_v);
		$display("[test] reset done");
		// A rising clock-2 alone must leave contents alone
		drv.hold(1'h1, 2'h0, 4'h9);
		drv.hold(1'h1, 2'h2, 4'h9);
		chk("rise only", 4'h0, stage_v);
		drv.hold(1'h1, 2'h0, 4'h9);
		chk("fall loads", 4'h9, stage_v);
		$display("[test] clock rise done");
		test_done;
	end
endmodule // test_dsr_top
